// File: hw/dpc_defs.vh
`ifndef DPC_DEFS_VH
`define DPC_DEFS_VH
// Clock rate and gain ramp timing
`define DPC_CLK_HZ        32'h05f5_e100
`define DPC_MS_CYC        (`DPC_CLK_HZ / 32'h0000_03e8)
`define DPC_RAMP_SHIFT    10
`define DPC_REL_UNIT_MS   32'h0000_0019
// Register offsets inside one channel; address bit 4 picks the channel
`define DPC_REG_COMP_THR  4'h0
`define DPC_REG_COMP_RAT  4'h1
`define DPC_REG_LIM_THR   4'h2
`define DPC_REG_KNEE      4'h3
`define DPC_REG_ATT       4'h4
`define DPC_REG_REL       4'h5
`define DPC_REG_MKUP      4'h6
`define DPC_REG_EXP_THR   4'h7
`define DPC_REG_EXP_RAT   4'h8
`define DPC_REG_EXP_KNEE  4'h9
`define DPC_REG_GATE_THR  4'ha
`define DPC_REG_EXP_ATT   4'hb
`define DPC_REG_EXP_REL   4'hc
`define DPC_REG_STATUS    4'hd
`define DPC_REG_MTR_IN    4'he
`define DPC_REG_MTR_GR    4'hf
// Legal setting ranges
`define DPC_RAT_MIN       8'h01
`define DPC_RAT_MAX       8'h04
`define DPC_KNEE_MIN      8'h01
`define DPC_KNEE_MAX      8'h28
`define DPC_ATT_MIN       8'h01
`define DPC_ATT_MAX       8'h63
`define DPC_REL_MIN       8'h02
`define DPC_REL_MAX       8'hc8
`define DPC_MKUP_MIN      8'he0
`define DPC_MKUP_MAX      8'h20
`define DPC_CTHR_MIN      8'ha6
`define DPC_CTHR_MAX      8'h00
`define DPC_XTHR_MIN      8'ha6
`define DPC_XTHR_MAX      8'hec
// Reset values
`define DPC_RST_THR       8'h00
`define DPC_RST_RAT       8'h01
`define DPC_RST_KNEE      8'h01
`define DPC_RST_ATT       8'h0a
`define DPC_RST_REL       8'h14
`define DPC_RST_MKUP      8'h00
`define DPC_RST_XTHR      8'ha6
`define DPC_RST_XATT      8'h32
// Level scale: 64 units per octave of amplitude
`define DPC_DB_MUL        13'h02ab
`define DPC_FS_UNITS      13'h03c0
`define DPC_RED_MAX       10'h3ff
`endif

// File: hw/dpc_gain_curve.v
`include "dpc_defs.vh"
// Static gain computer for one channel, purely combinational
module dpc_gain_curve (
    input  wire [9:0] level_in,      // Detected level, units
    input  wire [7:0] comp_thr_in,   // Compressor threshold, dB
    input  wire [7:0] comp_rat_in,   // Compression ratio code
    input  wire [7:0] lim_thr_in,    // Limiter threshold, dB
    input  wire [7:0] knee_in,       // Compressor knee, dB
    input  wire [7:0] exp_thr_in,    // Expander threshold, dB
    input  wire [7:0] exp_rat_in,    // Expansion ratio code
    input  wire [7:0] exp_knee_in,   // Expander knee, dB
    input  wire [7:0] gate_thr_in,   // Gate threshold, dB
    output reg  [9:0] comp_red_out,  // Compressor/limiter target
    output reg  [9:0] exp_red_out,   // Expander/gate target
    output reg        limit_on_out,  // Compression engaged
    output reg        gate_on_out    // Expansion or gating engaged
);
    // Threshold in dB to level units
    function signed [12:0] thr_u;
        input [7:0] db;
        reg signed [20:0] p;
        begin
            p = $signed(db) * $signed(`DPC_DB_MUL);
            thr_u = $signed(`DPC_FS_UNITS) + $signed(p[18:6]);
        end
    endfunction
    // Half knee width in units; knee 1 is a hard corner
    function [9:0] half_u;
        input [7:0] k;
        reg [15:0] p;
        begin
            p = k * `DPC_DB_MUL;
            half_u = (k == `DPC_KNEE_MIN) ? 10'h000 : {1'b0, p[15:7]};
        end
    endfunction
    // Reduction for distance past threshold; slope is per 48
    function [9:0] red;
        input signed [12:0] over;
        input [9:0]         half;
        input [7:0]         slope;
        input               mute;
        reg signed [13:0]   x;
        reg [31:0]          p;
        begin
            x = over + $signed({4'h0, half});
            if (x[13] || (x == 14'h0000)) begin
                p = 32'h0000_0000;
            end else if (over >= $signed({4'h0, half})) begin
                // Full ratio past the knee
                p = mute ? 32'h0000_03ff : ({19'h0, over} * slope) / 48;
            end else begin
                // Quadratic blend across the knee
                p = ({18'h0, x} * {18'h0, x} * slope) /
                    ({22'h0, half} * 192);
            end
            red = (p > 32'h0000_03ff) ? `DPC_RED_MAX : p[9:0];
        end
    endfunction
    // Inside or past the knee
    function eng;
        input signed [12:0] over;
        input [9:0]         half;
        reg signed [13:0]   x;
        begin
            x = over + $signed({4'h0, half});
            eng = !x[13] && (x != 14'h0000);
        end
    endfunction

    reg signed [12:0] oc, ol, ox, og;  // Distances past each threshold
    reg [9:0]         hc, hx;          // Half knees
    reg [7:0]         sc, sx;          // Slopes, per 48
    reg [9:0]         rc, rl, rx, rg;  // Per-stage reductions
    reg               xd, gd;          // Stage disabled

    always @* begin
        oc = $signed({3'b000, level_in}) - thr_u(comp_thr_in);
        ol = $signed({3'b000, level_in}) - thr_u(lim_thr_in);
        ox = thr_u(exp_thr_in) - $signed({3'b000, level_in});
        og = thr_u(gate_thr_in) - $signed({3'b000, level_in});
        hc = half_u(knee_in);
        hx = half_u(exp_knee_in);
        // 1:1, 2:1, 3:1, 4:1 remove 0, 1/2, 2/3, all of the rise
        case (comp_rat_in)
            8'h02:   sc = 8'h18;
            8'h03:   sc = 8'h20;
            8'h04:   sc = 8'h30;
            default: sc = 8'h00;
        endcase
        sx = (exp_rat_in - 8'h01) * 8'h30;
        xd = (exp_thr_in == `DPC_XTHR_MIN);
        gd = (gate_thr_in == `DPC_XTHR_MIN);
        rc = red(oc, hc, sc, 1'b0);
        rl = red(ol, hc, 8'h30, 1'b0);
        rx = xd ? 10'h000 :
             red(ox, hx, sx, exp_rat_in == `DPC_RAT_MAX);
        rg = gd ? 10'h000 : red(og, hx, 8'h90, 1'b1);
        comp_red_out = (rc > rl) ? rc : rl;
        exp_red_out = (rx > rg) ? rx : rg;
        limit_on_out = ((sc != 8'h00) && eng(oc, hc)) ||
                       eng(ol, hc);
        gate_on_out = (!xd && (sx != 8'h00) && eng(ox, hx)) ||
                      (!gd && eng(og, hx));
    end
endmodule

// File: hw/dpc_dynamics.v
`include "dpc_defs.vh"
// Operation
// - Make-up gain after compression, always active
// - Unity gain below compressor threshold
// - Above threshold output rises input/ratio
// - Highest ratio holds output constant
// - Compressor knee settable 1 to 40 dB
// - Knee 1 hard; 40 spans 20 dB each side
// - Independent limiter threshold, no rise above
// - Limiter shares knee, attack, release
// - Compressor attack 1 to 99 ms
// - Compressor release 50 ms to 5 s
// - Input and reduction meters per channel
// - Compressor settings held per channel
// - Limit indicator while compression engaged
// - Expander threshold -90 to -20, lowest off
// - Below threshold output falls ratio times faster
// - Highest expansion ratio gates completely
// - Expander knee 1 hard; 40 spans 20 dB
// - Separate gate threshold, rest shared
// - Expander attack to 99 ms, 1 ms steps
// - Expander release 50 ms to 5 s
// - Expander and gate settings per channel
// - Gate indicator while expansion or gating engaged
module dpc_dynamics #(
    parameter SW = 16                      // Sample width, level scale fits 16
) (
    input  wire          mclk_in,          // System clock
    input  wire          rst_n_in,         // Async reset, active low
    input  wire [4:0]    reg_addr_in,      // Register address
    input  wire [7:0]    reg_wdata_in,     // Write data
    input  wire          reg_wr_in,        // Write strobe
    input  wire          reg_rd_in,        // Read strobe
    output reg  [7:0]    reg_rdata_out,    // Read data, next cycle
    input  wire          smp_valid_in,     // Sample pair strobe
    input  wire [SW-1:0] smp_a_in,         // Channel A sample
    input  wire [SW-1:0] smp_b_in,         // Channel B sample
    output reg           smp_valid_out,    // Processed pair strobe
    output wire [SW-1:0] smp_a_out,        // Channel A result
    output wire [SW-1:0] smp_b_out,        // Channel B result
    output wire          limit_a_out,      // Channel A limit lamp
    output wire          limit_b_out,      // Channel B limit lamp
    output wire          gate_a_out,       // Channel A gate lamp
    output wire          gate_b_out        // Channel B gate lamp
);
    localparam signed [31:0] PMAX = (1 << (SW - 1)) - 1;  // Positive rail
    localparam signed [31:0] NMIN = -(1 << (SW - 1));     // Negative rail

    // Reset value of a setting
    function [7:0] dpc_dflt;
        input [3:0] f;
        begin
            case (f)
                `DPC_REG_COMP_RAT: dpc_dflt = `DPC_RST_RAT;
                `DPC_REG_KNEE:     dpc_dflt = `DPC_RST_KNEE;
                `DPC_REG_ATT:      dpc_dflt = `DPC_RST_ATT;
                `DPC_REG_REL:      dpc_dflt = `DPC_RST_REL;
                `DPC_REG_MKUP:     dpc_dflt = `DPC_RST_MKUP;
                `DPC_REG_EXP_THR:  dpc_dflt = `DPC_RST_XTHR;
                `DPC_REG_EXP_RAT:  dpc_dflt = `DPC_RST_RAT;
                `DPC_REG_EXP_KNEE: dpc_dflt = `DPC_RST_KNEE;
                `DPC_REG_GATE_THR: dpc_dflt = `DPC_RST_XTHR;
                `DPC_REG_EXP_ATT:  dpc_dflt = `DPC_RST_XATT;
                `DPC_REG_EXP_REL:  dpc_dflt = `DPC_RST_REL;
                default:           dpc_dflt = `DPC_RST_THR;
            endcase
        end
    endfunction

    // Unsigned range snap
    function [7:0] dpc_lim_u;
        input [7:0] v;
        input [7:0] lo;
        input [7:0] hi;
        begin
            if (v < lo) begin
                dpc_lim_u = lo;
            end else if (v > hi) begin
                dpc_lim_u = hi;
            end else begin
                dpc_lim_u = v;
            end
        end
    endfunction

    // Signed range snap
    function [7:0] dpc_lim_s;
        input [7:0] v;
        input [7:0] lo;
        input [7:0] hi;
        begin
            if ($signed(v) < $signed(lo)) begin
                dpc_lim_s = lo;
            end else if ($signed(v) > $signed(hi)) begin
                dpc_lim_s = hi;
            end else begin
                dpc_lim_s = v;
            end
        end
    endfunction

    // Out-of-range writes snap to the nearest legal setting
    function [7:0] dpc_clamp;
        input [3:0] f;
        input [7:0] v;
        begin
            case (f)
                `DPC_REG_COMP_RAT, `DPC_REG_EXP_RAT:
                    dpc_clamp = dpc_lim_u(v, `DPC_RAT_MIN, `DPC_RAT_MAX);
                `DPC_REG_KNEE, `DPC_REG_EXP_KNEE:
                    dpc_clamp = dpc_lim_u(v, `DPC_KNEE_MIN, `DPC_KNEE_MAX);
                `DPC_REG_ATT, `DPC_REG_EXP_ATT:
                    dpc_clamp = dpc_lim_u(v, `DPC_ATT_MIN, `DPC_ATT_MAX);
                `DPC_REG_REL, `DPC_REG_EXP_REL:
                    dpc_clamp = dpc_lim_u(v, `DPC_REL_MIN, `DPC_REL_MAX);
                `DPC_REG_MKUP:
                    dpc_clamp = dpc_lim_s(v, `DPC_MKUP_MIN, `DPC_MKUP_MAX);
                `DPC_REG_EXP_THR, `DPC_REG_GATE_THR:
                    dpc_clamp = dpc_lim_s(v, `DPC_XTHR_MIN, `DPC_XTHR_MAX);
                default:
                    dpc_clamp = dpc_lim_s(v, `DPC_CTHR_MIN, `DPC_CTHR_MAX);
            endcase
        end
    endfunction

    // Magnitude, saturated so the most negative code fits
    function [SW-2:0] dpc_abs;
        input [SW-1:0] s;
        reg [SW-1:0]   n;
        begin
            n = -s;
            if (!s[SW-1]) begin
                dpc_abs = s[SW-2:0];
            end else if (n[SW-1]) begin
                dpc_abs = {(SW-1){1'b1}};
            end else begin
                dpc_abs = n[SW-2:0];
            end
        end
    endfunction

    // Log2 level: octave index then six mantissa bits
    function [9:0] dpc_log;
        input [SW-2:0] a;
        integer        k;
        reg [3:0]      idx;
        reg [SW-2:0]   n;
        begin
            idx = 4'h0;
            for (k = 0; k < SW - 1; k = k + 1)
                if (a[k])
                    idx = k[3:0];
            n = a << (SW - 2 - idx);
            dpc_log = {idx, n[SW-3:SW-8]};
        end
    endfunction

    // Apply gain in level units; six bits below octave are linear
    function [SW-1:0] dpc_apply;
        input [SW-1:0]      s;
        input signed [12:0] e;
        reg signed [31:0]   v;
        reg signed [12:0]   sh;
        begin
            sh = $signed(13'h0006) - (e >>> 6);
            v = $signed(s) * $signed({2'b01, e[5:0]});
            v = v >>> sh[5:0];
            // Boost can overflow: clip at the rails
            if (v > PMAX) begin
                dpc_apply = PMAX[SW-1:0];
            end else if (v < NMIN) begin
                dpc_apply = NMIN[SW-1:0];
            end else begin
                dpc_apply = v[SW-1:0];
            end
        end
    endfunction

    reg  [7:0]    cfg [0:31];    // Settings, indexed {channel, field}
    integer       i;             // Reset loop index
    wire          lim_w  [0:1];  // Limit lamps
    wire          gate_w [0:1];  // Gate lamps
    wire [7:0]    mtr_in [0:1];  // Input meters
    wire [7:0]    mtr_gr [0:1];  // Reduction meters
    wire [SW-1:0] dout_w [0:1];  // Processed samples
    wire          rch = reg_addr_in[4];   // Channel picked by the bus

    // Setting store; each channel owns its own copy
    always @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (i = 0; i < 32; i = i + 1)
                cfg[i] <= dpc_dflt(i[3:0]);
        end else if (reg_wr_in &&
                     (reg_addr_in[3:0] < `DPC_REG_STATUS)) begin
            cfg[reg_addr_in] <= dpc_clamp(reg_addr_in[3:0],
                                          reg_wdata_in);
        end
    end

    // Read port; data stand only in the cycle after the strobe
    always @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            reg_rdata_out <= 8'h00;
        end else if (!reg_rd_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_addr_in[3:0] == `DPC_REG_STATUS) begin
            reg_rdata_out <= {6'h00, gate_w[rch], lim_w[rch]};
        end else if (reg_addr_in[3:0] == `DPC_REG_MTR_IN) begin
            reg_rdata_out <= mtr_in[rch];
        end else if (reg_addr_in[3:0] == `DPC_REG_MTR_GR) begin
            reg_rdata_out <= mtr_gr[rch];
        end else begin
            reg_rdata_out <= cfg[reg_addr_in];
        end
    end

    // Output strobe trails the input strobe by one clock
    always @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            smp_valid_out <= 1'b0;
        end else begin
            smp_valid_out <= smp_valid_in;
        end
    end

    genvar c, j;
    generate
        for (c = 0; c < 2; c = c + 1) begin : g_ch
            localparam [4:0] B = (c == 0) ? 5'h00 : 5'h10;  // Channel base
            wire [SW-1:0] din = (c == 0) ? smp_a_in : smp_b_in;
            wire [9:0]    lv = dpc_log(dpc_abs(din));  // Instant level
            reg  [9:0]    det;              // Peak-hold level
            reg  [9:0]    tgt [0:1];        // Curve targets, comp and exp
            reg           lim;              // Limit lamp
            reg           gat;              // Gate lamp
            reg  [SW-1:0] dout;             // Processed sample
            wire [9:0]    cr;               // Compressor target
            wire [9:0]    xr;               // Expander target
            wire          lon;              // Compression engaged
            wire          gon;              // Expansion engaged
            wire [9:0]    gs [0:1];         // Smoothed reductions
            wire signed [20:0] mkp = $signed(cfg[B + `DPC_REG_MKUP]) *
                                     $signed(`DPC_DB_MUL);
            wire signed [12:0] ex = $signed(mkp[18:6]) -
                                    $signed({3'b000, gs[0]}) -
                                    $signed({3'b000, gs[1]});
            wire [10:0]   grs = {1'b0, gs[0]} + {1'b0, gs[1]};

            dpc_gain_curve u_curve (
                .level_in     (det),
                .comp_thr_in  (cfg[B + `DPC_REG_COMP_THR]),
                .comp_rat_in  (cfg[B + `DPC_REG_COMP_RAT]),
                .lim_thr_in   (cfg[B + `DPC_REG_LIM_THR]),
                .knee_in      (cfg[B + `DPC_REG_KNEE]),
                .exp_thr_in   (cfg[B + `DPC_REG_EXP_THR]),
                .exp_rat_in   (cfg[B + `DPC_REG_EXP_RAT]),
                .exp_knee_in  (cfg[B + `DPC_REG_EXP_KNEE]),
                .gate_thr_in  (cfg[B + `DPC_REG_GATE_THR]),
                .comp_red_out (cr),
                .exp_red_out  (xr),
                .limit_on_out (lon),
                .gate_on_out  (gon)
            );

            // Detector, targets, lamps and the gain multiply
            always @(posedge mclk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    det <= 10'h000;
                    tgt[0] <= 10'h000;
                    tgt[1] <= 10'h000;
                    lim <= 1'b0;
                    gat <= 1'b0;
                    dout <= {SW{1'b0}};
                end else begin
                    tgt[0] <= cr;
                    tgt[1] <= xr;
                    lim <= lon;
                    gat <= gon;
                    if (smp_valid_in) begin
                        // Peak hold decays one unit a sample, so a
                        // zero crossing does not open the gain
                        if (lv >= det) begin
                            det <= lv;
                        end else begin
                            det <= det - 10'h001;
                        end
                        dout <= dpc_apply(din, ex);
                    end
                end
            end

            // Two smoothers: index 0 compressor, 1 expander
            for (j = 0; j < 2; j = j + 1) begin : g_sm
                reg  [9:0]  gsm;              // Smoothed reduction
                reg  [31:0] cnt;              // Clocks since last step
                wire        up = tgt[j] > gsm;
                wire [7:0]  att = (j == 0) ? cfg[B + `DPC_REG_ATT] :
                                  cfg[B + `DPC_REG_EXP_ATT];
                wire [7:0]  rel = (j == 0) ? cfg[B + `DPC_REG_REL] :
                                  cfg[B + `DPC_REG_EXP_REL];
                // Expander attack is the return to unity, so swap
                wire        use_att = (j == 0) ? up : !up;
                wire [31:0] t_ms = use_att ? {24'h00_0000, att} :
                                   rel * `DPC_REL_UNIT_MS;
                // Full-scale ramp of 1024 steps spans the set time
                wire [31:0] per = (t_ms * `DPC_MS_CYC) >> `DPC_RAMP_SHIFT;

                always @(posedge mclk_in or negedge rst_n_in) begin
                    if (!rst_n_in) begin
                        gsm <= 10'h000;
                        cnt <= 32'h0000_0000;
                    end else if (tgt[j] == gsm) begin
                        cnt <= 32'h0000_0000;
                    end else if (cnt >= per) begin
                        cnt <= 32'h0000_0000;
                        if (up) begin
                            gsm <= gsm + 10'h001;
                        end else begin
                            gsm <= gsm - 10'h001;
                        end
                    end else begin
                        cnt <= cnt + 32'h0000_0001;
                    end
                end
                assign gs[j] = gsm;
            end

            assign lim_w[c] = lim;
            assign gate_w[c] = gat;
            assign dout_w[c] = dout;
            assign mtr_in[c] = det[9:2];
            assign mtr_gr[c] = grs[10] ? 8'hff : grs[9:2];
        end
    endgenerate

    assign smp_a_out = dout_w[0];
    assign smp_b_out = dout_w[1];
    assign limit_a_out = lim_w[0];
    assign limit_b_out = lim_w[1];
    assign gate_a_out = gate_w[0];
    assign gate_b_out = gate_w[1];
endmodule

// File: tb/dpc_dynamics_properties.sv
// Checks on register reads and the sample stream
module dpc_props #(
    parameter SW = 16                 // Sample width
) (
    input wire          mclk_in,       // System clock
    input wire          rst_n_in,      // Async reset, active low
    input wire          reg_rd_in,     // Read strobe
    input wire [7:0]    reg_rdata_out, // Read data
    input wire          smp_valid_in,  // Input pair strobe
    input wire [SW-1:0] smp_a_in,      // Channel A input
    input wire [SW-1:0] smp_b_in,      // Channel B input
    input wire          smp_valid_out, // Output pair strobe
    input wire [SW-1:0] smp_a_out,     // Channel A result
    input wire [SW-1:0] smp_b_out      // Channel B result
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);

    // Meter and setting data only in the read slot
    a_rdata_idle: assert property (
        !$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
        else $error("Read data outside its slot");
    a_valid_lat: assert property (
        smp_valid_in |=> smp_valid_out)
        else $error("Output strobe missing");
    a_valid_only: assert property (
        smp_valid_out |-> $past(smp_valid_in))
        else $error("Output strobe without input");
    // Results hold between pairs
    a_out_hold: assert property (
        !smp_valid_out |-> $stable(smp_a_out) && $stable(smp_b_out))
        else $error("Result moved between pairs");
    // Gain is a factor: silence stays silent
    a_zero_a: assert property (
        smp_valid_in && smp_a_in == 0 |=> smp_a_out == 0)
        else $error("Channel A silence not kept");
    a_zero_b: assert property (
        smp_valid_in && smp_b_in == 0 |=> smp_b_out == 0)
        else $error("Channel B silence not kept");
    // Gain never flips polarity, mute may reach zero
    a_sign_a: assert property (
        smp_valid_in && !smp_a_in[SW-1] |=> !smp_a_out[SW-1])
        else $error("Channel A polarity flipped");
    a_sign_b: assert property (
        smp_valid_in && smp_b_in[SW-1]
        |=> smp_b_out[SW-1] || smp_b_out == 0)
        else $error("Channel B polarity flipped");
endmodule

bind dpc_dynamics dpc_props #(.SW(SW)) u_props (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .smp_valid_in(smp_valid_in),
    .smp_a_in(smp_a_in), .smp_b_in(smp_b_in),
    .smp_valid_out(smp_valid_out), .smp_a_out(smp_a_out),
    .smp_b_out(smp_b_out));

// File: tb/dpc_audio_src.sv
// Input converter stand-in: a pair every 8 clocks, polarity alternating
module dpc_audio_src (
    input  wire         clk_in,    // System clock
    input  wire         rst_n_in,  // Async reset, active low
    input  wire  [15:0] amp_a_in,  // Channel A amplitude
    input  wire  [15:0] amp_b_in,  // Channel B amplitude
    output logic        valid_out, // Pair strobe
    output logic [15:0] a_out,     // Channel A sample
    output logic [15:0] b_out      // Channel B sample
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt;               // Frame phase, top bit is polarity

    // Lines invert between strobes so stale data is never mistaken
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt <= 4'h0;
            valid_out <= 1'b0;
            a_out <= 16'h0000;
            b_out <= 16'h0000;
        end else if (cnt[2:0] == 3'h0) begin
            cnt <= cnt + 4'h1;
            valid_out <= 1'b1;
            a_out <= cnt[3] ? -amp_a_in : amp_a_in;
            b_out <= cnt[3] ? -amp_b_in : amp_b_in;
        end else begin
            cnt <= cnt + 4'h1;
            valid_out <= 1'b0;
            a_out <= ~a_out;
            b_out <= ~b_out;
        end
    end
endmodule

// File: tb/tb_dpc_dynamics.sv
module tb_dpc_dynamics;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk_in = 1'b0;              // 100 MHz clock
    logic        rst_n_in = 1'b0;             // Reset, active low
    logic        reg_wr_in = 1'b0;            // Write strobe
    logic        reg_rd_in = 1'b0;            // Read strobe
    logic [4:0]  reg_addr_in = 5'h00;         // Register address
    logic [7:0]  reg_wdata_in = 8'h00;        // Write data
    logic [15:0] amp_a = 16'h0000, amp_b = 16'h0000; // Source levels
    logic [7:0]  reg_rdata_out, v1, v2;       // Read data, meter reads
    logic [15:0] smp_a_in, smp_b_in, smp_a_out, smp_b_out;
    logic        smp_valid_in, smp_valid_out; // Pair strobes
    logic        limit_a_out, limit_b_out, gate_a_out, gate_b_out;
    int          err_count = 0;
    int          checks = 0;
    // Reset values of fields 0 to C
    logic [7:0]  rst_tbl [13] = '{8'h00, 8'h01, 8'h00, 8'h01, 8'h0a,
        8'h14, 8'h00, 8'ha6, 8'h01, 8'h01, 8'ha6, 8'h32, 8'h14};
    // Field, written, read back; short times last except expander attack
    logic [19:0] clamp_tbl [15] = '{20'h3_29_28, 20'h3_00_01,
        20'h4_64_63, 20'h4_00_01, 20'h5_c9_c8, 20'h5_01_02,
        20'h7_f6_ec, 20'h7_9c_a6, 20'hb_64_63, 20'hc_01_02,
        20'h1_05_04, 20'h8_05_04, 20'hd_ff_00, 20'he_ff_00,
        20'hf_ff_00};

    dpc_dynamics uut (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .smp_valid_in(smp_valid_in),
        .smp_a_in(smp_a_in), .smp_b_in(smp_b_in),
        .smp_valid_out(smp_valid_out), .smp_a_out(smp_a_out),
        .smp_b_out(smp_b_out), .limit_a_out(limit_a_out),
        .limit_b_out(limit_b_out), .gate_a_out(gate_a_out),
        .gate_b_out(gate_b_out));
    dpc_audio_src src (.clk_in(mclk_in), .rst_n_in(rst_n_in),
        .amp_a_in(amp_a), .amp_b_in(amp_b), .valid_out(smp_valid_in),
        .a_out(smp_a_in), .b_out(smp_b_in));

    initial forever #5 mclk_in = ~mclk_in;

    task automatic chk(input string n, input logic [15:0] s, e);
        checks++;
        if (s !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge mclk_in);
        reg_wr_in <= 1'b0;
    endtask
    // Data stand only in the cycle after the strobe
    task automatic rd(input logic [4:0] a, output logic [7:0] v);
        @(posedge mclk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge mclk_in);
        reg_rd_in <= 1'b0;
        #1 v = reg_rdata_out;
    endtask
    task automatic rc(input logic [4:0] a, input logic [7:0] e);
        logic [7:0] v;
        rd(a, v);
        chk("register", {8'h00, v}, {8'h00, e});
    endtask
    // Polarity follows the source; compare magnitudes
    function automatic logic [15:0] mag(input logic [15:0] s);
        return s[15] ? -s : s;
    endfunction
    task automatic finish_test;
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Watchdog, run needs about 3800 clocks
    initial begin
        #200_000;
        err_count++;
        finish_test();
    end

    initial begin
        repeat (8) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        for (int i = 0; i < 13; i++) begin
            rc(5'(i), rst_tbl[i]);
            rc(5'(i + 16), rst_tbl[i]);
        end
        // Out-of-range settings clamp, read-only fields ignore writes
        for (int i = 0; i < 15; i++) begin
            wr({1'b0, clamp_tbl[i][19:16]}, clamp_tbl[i][15:8]);
            rc({1'b0, clamp_tbl[i][19:16]},
               clamp_tbl[i][7:0]);
        end
        rc(5'h13, 8'h01);
        amp_a <= 16'h1000;
        amp_b <= 16'h1000;
        repeat (64) @(negedge mclk_in);
        chk("unity a", mag(smp_a_out), 16'h1000);
        chk("limit a", {15'h0, limit_a_out}, 16'h0000);
        wr(5'h06, 8'h06);
        repeat (64) @(negedge mclk_in);
        chk("makeup a", mag(smp_a_out), 16'h2000);
        chk("makeup b", mag(smp_b_out), 16'h1000);
        // Loud A over a low threshold at the limiting ratio
        wr(5'h00, 8'he2);
        amp_a <= 16'h4000;
        repeat (300) @(posedge mclk_in);
        rd(5'h0f, v1);
        repeat (3000) @(posedge mclk_in);
        rd(5'h0f, v2);
        chk("reduction grows", {15'h0, v2 > v1}, 16'h0001);
        chk("limit a", {15'h0, limit_a_out}, 16'h0001);
        chk("limit b", {15'h0, limit_b_out}, 16'h0000);
        // Quiet B under a raised threshold at the gating ratio
        wr(5'h17, 8'hec);
        wr(5'h18, 8'h04);
        amp_b <= 16'h0010;
        repeat (256) @(negedge mclk_in);
        chk("gate b", {15'h0, gate_b_out}, 16'h0001);
        chk("gate a", {15'h0, gate_a_out}, 16'h0000);
        finish_test();
    end
endmodule
